//--- cbtmr_defines.svh
// Constants for the configuration bus, radiation monitor and scrubber
//
// Contract
// (R1) Main configuration bus carries 32-bit transaction words.
// (R2) Each attached module owns a distinct module address and 16-bit registers.
// (R3) Two independent masters may each issue reads and writes.
// (R4) First master takes commands from the USB bridge interface.
// (R5) Link decoder turns single-word transactions in frames into bus commands.
// (R6) Word packs write flag, module address, register address, 16-bit value.
// (R7) Scrubber bus is 15 bits: 7-bit address and 8-bit data.
// (R8) Scrubber bus has two masters: I2C side and UART side.
// (R9) Sensor control module holds clock line mask at register 0x15.
// (R10) Protected logic is combinational blocks ending in registers, no feedback.
// (R11) Each protected block is tripled, feeding three separate voters.
// (R12) Voter is combinational and follows at least two of three inputs.
// (R13) Voter gives two identical mismatch outputs when any input disagrees.
// (R14) Radiation monitor counts voter mismatches, readable over the bus.
// (R15) Data-valid outputs drive three redundant pins.
// (R16) Scrubber programs target through its parallel port from a golden image.
// (R17) Two modes: initial programming with reset, and continuous scrubbing.
// (R18) Scrubber uses tripled flip-flops feeding one untripled voter.
// (R19) Arbiter grants one master at a time until its transaction completes.
`ifndef CBTMR_DEFINES_SVH
`define CBTMR_DEFINES_SVH

`define CB_WORD_W        32
`define CB_DATA_W        16
`define CB_LINK_W        80
`define CB_SGL_HDR       4'h3
`define CB_SGL_HDR_HI    79
`define CB_SGL_HDR_LO    76
`define CB_MOD_SENSOR    7'h01
`define CB_MOD_RADMON    7'h02
`define CB_REG_CLK_MASK  8'h15
`define CB_CLK_MASK_RST  16'h0000
`define CB_RAD_NUM       3
`define CB_RAD_CNT_MAX   16'hffff

`define SB_ADDR_W        7
`define SB_DATA_W        8
`define SB_REG_CTRL      7'h00
`define SB_REG_STAT      7'h01
`define SB_CTRL_PROG     0
`define SB_CTRL_SCRUB    1
`define SB_CLK_MHZ       25
`define SB_PROG_PULSE_NS 1000
`define SB_PROG_PULSE_CYC \
  ((`SB_PROG_PULSE_NS * `SB_CLK_MHZ + 999) / 1000)
`define SB_IMG_LAST      16'hffff
`define SB_FLASH_W       16

`endif

//--- cbtmr_pkg.sv
// Types shared by the configuration bus and scrubber logic
package cbtmr_pkg;

  typedef struct packed {
    logic        wr;
    logic [6:0]  module_addr;
    logic [7:0]  reg_addr;
    logic [15:0] value;
  } cbtmr_txn_t;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } cbtmr_scmd_t;

  typedef enum logic [2:0] {
    CBTMR_ARB_IDLE = 3'b001,
    CBTMR_ARB_USB  = 3'b010,
    CBTMR_ARB_LINK = 3'b100
  } cbtmr_arb_t;

  typedef enum logic [4:0] {
    CBTMR_SQ_IDLE  = 5'b00001,
    CBTMR_SQ_RESET = 5'b00010,
    CBTMR_SQ_LOAD  = 5'b00100,
    CBTMR_SQ_INIT  = 5'b01000,
    CBTMR_SQ_SCRUB = 5'b10000
  } cbtmr_sq_state_t;

  typedef struct packed {
    cbtmr_sq_state_t st;
    logic [15:0]     cnt;
  } cbtmr_sq_t;

endpackage

//--- cbtmr_voter.sv
// Bitwise two-of-three majority voter with twin mismatch flags
`timescale 1ns/1ns
`default_nettype none
module cbtmr_voter #(
  parameter int W = 1
) (
  input  wire logic [W-1:0] a_in,
  input  wire logic [W-1:0] b_in,
  input  wire logic [W-1:0] c_in,
  output logic      [W-1:0] voted_out,
  output logic              mism_a_out,
  output logic              mism_b_out
);
  logic [W-1:0] vote;
  logic         mism;

  // (R12) Two of three wins
  assign vote = (a_in & b_in) | (a_in & c_in) | (b_in & c_in);
  assign voted_out = vote;
  // (R13) Twin mismatch flags
  assign mism = (a_in != vote) || (b_in != vote) || (c_in != vote);
  assign mism_a_out = mism;
  assign mism_b_out = mism;
endmodule // cbtmr_voter
`default_nettype wire

//--- cbtmr_top.sv
// Configuration bus with two masters, TMR monitor and scrub controller
`timescale 1ns/1ns
`default_nettype none
`include "cbtmr_defines.svh"
module cbtmr_top #(
  parameter logic [15:0] IMG_LAST = `SB_IMG_LAST
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    usb_cmd_valid_in,
  input  wire cbtmr_pkg::cbtmr_txn_t   usb_cmd_in,
  output logic                         usb_cmd_ready_out,
  output logic                         usb_rsp_valid_out,
  output cbtmr_pkg::cbtmr_txn_t        usb_rsp_out,
  input  wire logic                    link_dv_in,
  input  wire logic [`CB_LINK_W-1:0]   link_frame_in,
  output logic                         link_rsp_valid_out,
  output cbtmr_pkg::cbtmr_txn_t        link_rsp_out,
  output logic [`CB_DATA_W-1:0]        sensor_clk_en_out,
  input  wire logic                    tx_dv_in,
  output logic [2:0]                   tx_dv_pins_out,
  input  wire logic                    i2c_cmd_valid_in,
  input  wire cbtmr_pkg::cbtmr_scmd_t  i2c_cmd_in,
  output logic                         i2c_cmd_ready_out,
  input  wire logic                    uart_cmd_valid_in,
  input  wire cbtmr_pkg::cbtmr_scmd_t  uart_cmd_in,
  output logic                         uart_cmd_ready_out,
  output logic                         sb_rvalid_out,
  output logic [`SB_DATA_W-1:0]        sb_rdata_out,
  output logic                         cfg_prog_n_out,
  output logic                         cfg_wr_out,
  output logic [`SB_FLASH_W-1:0]       cfg_data_out,
  input  wire logic                    cfg_done_in,
  output logic                         flash_rd_out,
  output logic [15:0]                  flash_addr_out,
  input  wire logic [`SB_FLASH_W-1:0]  flash_data_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Main bus arbiter and register access

  cbtmr_pkg::cbtmr_arb_t arb_ff, nxt_arb;
  // (R1) 32-bit words on the main bus
  cbtmr_pkg::cbtmr_txn_t txn_ff, nxt_txn;
  cbtmr_pkg::cbtmr_txn_t link_txn_ff, nxt_link_txn;
  cbtmr_pkg::cbtmr_txn_t usb_rsp_ff, nxt_usb_rsp;
  cbtmr_pkg::cbtmr_txn_t link_rsp_ff, nxt_link_rsp;
  logic                  link_pend_ff, nxt_link_pend;
  logic                  last_usb_ff, nxt_last_usb;
  logic                  usb_ready_ff, nxt_usb_ready;
  logic                  usb_rv_ff, nxt_usb_rv;
  logic                  link_rv_ff, nxt_link_rv;
  logic [15:0]           mask_ff, nxt_mask;
  logic [`CB_RAD_NUM-1:0] rad_clr;
  logic [15:0]           rad_cnt [`CB_RAD_NUM];
  logic [15:0]           rdata;
  logic                  sgl_seen;
  logic                  pick_usb;

  // (R5) Single-word transaction detect
  assign sgl_seen = !link_dv_in &&
    (link_frame_in[`CB_SGL_HDR_HI:`CB_SGL_HDR_LO] == `CB_SGL_HDR);

  always_comb begin
    nxt_arb       = arb_ff;
    nxt_txn       = txn_ff;
    nxt_link_txn  = link_txn_ff;
    nxt_link_pend = link_pend_ff;
    nxt_last_usb  = last_usb_ff;
    nxt_usb_ready = 1'b0;
    nxt_usb_rv    = 1'b0;
    nxt_link_rv   = 1'b0;
    nxt_usb_rsp   = usb_rsp_ff;
    nxt_link_rsp  = link_rsp_ff;
    nxt_mask      = mask_ff;
    rad_clr       = '0;
    rdata         = 16'h0000;
    // Alternate when both wait so neither master starves
    pick_usb = usb_cmd_valid_in && (!link_pend_ff || !last_usb_ff);
    // (R2) Module and register decode
    case (txn_ff.module_addr)
      `CB_MOD_SENSOR: begin
        if (txn_ff.reg_addr == `CB_REG_CLK_MASK) begin
          rdata = mask_ff;
        end
      end
      `CB_MOD_RADMON: begin
        for (int i = 0; i < `CB_RAD_NUM; i++) begin
          if (txn_ff.reg_addr == 8'(i)) begin
            rdata = rad_cnt[i];
          end
        end
      end
      default: rdata = 16'h0000;
    endcase
    // (R19) One grant at a time
    case (arb_ff)
      cbtmr_pkg::CBTMR_ARB_IDLE: begin
        // (R3) Either master may be granted
        if (pick_usb) begin
          // (R4) USB command taken
          nxt_txn       = usb_cmd_in;
          nxt_usb_ready = 1'b1;
          nxt_last_usb  = 1'b1;
          nxt_arb       = cbtmr_pkg::CBTMR_ARB_USB;
        end else if (link_pend_ff) begin
          nxt_txn       = link_txn_ff;
          nxt_link_pend = 1'b0;
          nxt_last_usb  = 1'b0;
          nxt_arb       = cbtmr_pkg::CBTMR_ARB_LINK;
        end
      end
      cbtmr_pkg::CBTMR_ARB_USB,
      cbtmr_pkg::CBTMR_ARB_LINK: begin
        // (R6) Word fields steer the access
        if (txn_ff.wr) begin
          // (R9) Clock line mask write
          if (txn_ff.module_addr == `CB_MOD_SENSOR &&
              txn_ff.reg_addr == `CB_REG_CLK_MASK) begin
            nxt_mask = txn_ff.value;
          end
          if (txn_ff.module_addr == `CB_MOD_RADMON) begin
            for (int i = 0; i < `CB_RAD_NUM; i++) begin
              rad_clr[i] = (txn_ff.reg_addr == 8'(i));
            end
          end
        end
        if (arb_ff == cbtmr_pkg::CBTMR_ARB_USB) begin
          nxt_usb_rv  = 1'b1;
          nxt_usb_rsp = txn_ff;
          if (!txn_ff.wr) nxt_usb_rsp.value = rdata;
        end else begin
          nxt_link_rv  = 1'b1;
          nxt_link_rsp = txn_ff;
          if (!txn_ff.wr) nxt_link_rsp.value = rdata;
        end
        nxt_arb = cbtmr_pkg::CBTMR_ARB_IDLE;
      end
      default: nxt_arb = cbtmr_pkg::CBTMR_ARB_IDLE;
    endcase
    // A new frame beats the clear; one arriving while full is dropped
    if (sgl_seen && !nxt_link_pend) begin
      nxt_link_pend = 1'b1;
      nxt_link_txn  = link_frame_in[`CB_WORD_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arb_ff       <= cbtmr_pkg::CBTMR_ARB_IDLE;
      txn_ff       <= '0;
      link_txn_ff  <= '0;
      link_pend_ff <= 1'b0;
      last_usb_ff  <= 1'b0;
      usb_ready_ff <= 1'b0;
      usb_rv_ff    <= 1'b0;
      link_rv_ff   <= 1'b0;
      usb_rsp_ff   <= '0;
      link_rsp_ff  <= '0;
      mask_ff      <= `CB_CLK_MASK_RST;
    end else begin
      arb_ff       <= nxt_arb;
      txn_ff       <= nxt_txn;
      link_txn_ff  <= nxt_link_txn;
      link_pend_ff <= nxt_link_pend;
      last_usb_ff  <= nxt_last_usb;
      usb_ready_ff <= nxt_usb_ready;
      usb_rv_ff    <= nxt_usb_rv;
      link_rv_ff   <= nxt_link_rv;
      usb_rsp_ff   <= nxt_usb_rsp;
      link_rsp_ff  <= nxt_link_rsp;
      mask_ff      <= nxt_mask;
    end
  end

  assign usb_cmd_ready_out  = usb_ready_ff;
  assign usb_rsp_valid_out  = usb_rv_ff;
  assign usb_rsp_out        = usb_rsp_ff;
  assign link_rsp_valid_out = link_rv_ff;
  assign link_rsp_out       = link_rsp_ff;
  assign sensor_clk_en_out  = mask_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Tripled data-valid path, voters, pins and mismatch counters

  logic [2:0] dv_ff;
  logic [2:0] pin_ff;
  logic [2:0] voted;
  logic [2:0] mism_a;
  logic [2:0] mism_b;

  for (genvar g = 0; g < `CB_RAD_NUM; g++) begin : g_tmr
    logic [15:0] cnt_ff, nxt_cnt;
    logic        hit;

    // (R11) One of three voters
    cbtmr_voter #(.W(1)) u_vote (
      .a_in       (dv_ff[0]),
      .b_in       (dv_ff[1]),
      .c_in       (dv_ff[2]),
      .voted_out  (voted[g]),
      .mism_a_out (mism_a[g]),
      .mism_b_out (mism_b[g])
    );

    // (R14) Count mismatches; a clear with a hit in the same cycle leaves the count at one
    always_comb begin
      hit     = mism_a[g] | mism_b[g];
      nxt_cnt = rad_clr[g] ? 16'h0000 : cnt_ff;
      if (hit && nxt_cnt != `CB_RAD_CNT_MAX) begin
        nxt_cnt = nxt_cnt + 16'h0001;
      end
    end

    // (R10) Block is input logic ending in a register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        dv_ff[g]  <= 1'b0;
        pin_ff[g] <= 1'b0;
        cnt_ff    <= 16'h0000;
      end else begin
        dv_ff[g]  <= tx_dv_in;
        pin_ff[g] <= voted[g];
        cnt_ff    <= nxt_cnt;
      end
    end

    assign rad_cnt[g] = cnt_ff;
  end

  // (R15) Three redundant data-valid pins
  assign tx_dv_pins_out = pin_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Scrubber 15-bit bus with I2C and UART masters

  logic                  sb_busy_ff, nxt_sb_busy;
  logic                  i2c_rdy_ff, nxt_i2c_rdy;
  logic                  uart_rdy_ff, nxt_uart_rdy;
  logic                  sb_rv_ff, nxt_sb_rv;
  logic [7:0]            sb_rdata_ff, nxt_sb_rdata;
  logic                  scrub_en_ff, nxt_scrub_en;
  logic                  start_ff, nxt_start;
  cbtmr_pkg::cbtmr_scmd_t scmd;
  logic                  stake;
  cbtmr_pkg::cbtmr_sq_t  sq_v;

  // (R7) Seven address bits and eight data bits
  // (R8) I2C master first, UART second
  always_comb begin
    nxt_sb_busy  = 1'b0;
    nxt_i2c_rdy  = 1'b0;
    nxt_uart_rdy = 1'b0;
    nxt_sb_rv    = 1'b0;
    nxt_sb_rdata = sb_rdata_ff;
    nxt_scrub_en = scrub_en_ff;
    nxt_start    = 1'b0;
    scmd         = i2c_cmd_valid_in ? i2c_cmd_in : uart_cmd_in;
    stake        = !sb_busy_ff && (i2c_cmd_valid_in || uart_cmd_valid_in);
    if (stake) begin
      nxt_sb_busy  = 1'b1;
      nxt_i2c_rdy  = i2c_cmd_valid_in;
      nxt_uart_rdy = !i2c_cmd_valid_in;
      if (scmd.wr) begin
        if (scmd.addr == `SB_REG_CTRL) begin
          nxt_start    = scmd.data[`SB_CTRL_PROG];
          nxt_scrub_en = scmd.data[`SB_CTRL_SCRUB];
        end
      end else begin
        nxt_sb_rv = 1'b1;
        case (scmd.addr)
          `SB_REG_CTRL: nxt_sb_rdata = {6'h00, scrub_en_ff, 1'b0};
          `SB_REG_STAT: nxt_sb_rdata = {3'h0, sq_v.st};
          default:      nxt_sb_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sb_busy_ff  <= 1'b0;
      i2c_rdy_ff  <= 1'b0;
      uart_rdy_ff <= 1'b0;
      sb_rv_ff    <= 1'b0;
      sb_rdata_ff <= 8'h00;
      scrub_en_ff <= 1'b0;
      start_ff    <= 1'b0;
    end else begin
      sb_busy_ff  <= nxt_sb_busy;
      i2c_rdy_ff  <= nxt_i2c_rdy;
      uart_rdy_ff <= nxt_uart_rdy;
      sb_rv_ff    <= nxt_sb_rv;
      sb_rdata_ff <= nxt_sb_rdata;
      scrub_en_ff <= nxt_scrub_en;
      start_ff    <= nxt_start;
    end
  end

  assign i2c_cmd_ready_out  = i2c_rdy_ff;
  assign uart_cmd_ready_out = uart_rdy_ff;
  assign sb_rvalid_out      = sb_rv_ff;
  assign sb_rdata_out       = sb_rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Programming and scrubbing sequencer with tripled state

  cbtmr_pkg::cbtmr_sq_t sq_ff [3];
  cbtmr_pkg::cbtmr_sq_t nxt_sq;
  logic                 done_s1_ff, done_s2_ff;
  logic                 rd_ff, nxt_rd, rd_d_ff, wr_ff;
  logic                 prog_n_ff, nxt_prog_n;
  logic [15:0]          faddr_ff, nxt_faddr;
  logic [15:0]          cfg_data_ff;
  logic [15:0]          pulse_last;

  assign pulse_last = 16'(`SB_PROG_PULSE_CYC - 1);

  // (R18) Single voter over tripled flops
  cbtmr_voter #(.W($bits(cbtmr_pkg::cbtmr_sq_t))) u_sq_vote (
    .a_in       (sq_ff[0]),
    .b_in       (sq_ff[1]),
    .c_in       (sq_ff[2]),
    .voted_out  (sq_v),
    .mism_a_out (),
    .mism_b_out ()
  );

  // (R17) Initial programming, then optional scrubbing
  always_comb begin
    nxt_sq     = sq_v;
    nxt_rd     = 1'b0;
    nxt_prog_n = 1'b1;
    nxt_faddr  = faddr_ff;
    case (sq_v.st)
      cbtmr_pkg::CBTMR_SQ_IDLE: begin
        if (start_ff) begin
          nxt_sq.st  = cbtmr_pkg::CBTMR_SQ_RESET;
          nxt_sq.cnt = 16'h0000;
          nxt_prog_n = 1'b0;
        end
      end
      cbtmr_pkg::CBTMR_SQ_RESET: begin
        nxt_prog_n = 1'b0;
        nxt_sq.cnt = sq_v.cnt + 16'h0001;
        if (sq_v.cnt == pulse_last) begin
          nxt_prog_n = 1'b1;
          nxt_sq.st  = cbtmr_pkg::CBTMR_SQ_LOAD;
          nxt_sq.cnt = 16'h0000;
        end
      end
      cbtmr_pkg::CBTMR_SQ_LOAD,
      cbtmr_pkg::CBTMR_SQ_SCRUB: begin
        // (R16) Golden image words to the parallel port
        nxt_rd     = 1'b1;
        nxt_faddr  = sq_v.cnt;
        nxt_sq.cnt = sq_v.cnt + 16'h0001;
        if (sq_v.cnt == IMG_LAST) begin
          // Wrap so every scrub pass restarts at word 0
          nxt_sq.cnt = 16'h0000;
          if (sq_v.st == cbtmr_pkg::CBTMR_SQ_LOAD) begin
            nxt_sq.st = cbtmr_pkg::CBTMR_SQ_INIT;
          end else if (!scrub_en_ff) begin
            nxt_sq.st = cbtmr_pkg::CBTMR_SQ_IDLE;
          end
        end
      end
      cbtmr_pkg::CBTMR_SQ_INIT: begin
        nxt_sq.cnt = 16'h0000;
        if (done_s2_ff) begin
          nxt_sq.st = scrub_en_ff ? cbtmr_pkg::CBTMR_SQ_SCRUB
                                  : cbtmr_pkg::CBTMR_SQ_IDLE;
        end
      end
      default: begin
        nxt_sq.st  = cbtmr_pkg::CBTMR_SQ_IDLE;
        nxt_sq.cnt = 16'h0000;
      end
    endcase
  end

  // Flash answers one cycle after the read, so the write lags by two
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 3; i++) begin
        sq_ff[i] <= '{st: cbtmr_pkg::CBTMR_SQ_IDLE, cnt: 16'h0000};
      end
      done_s1_ff  <= 1'b0;
      done_s2_ff  <= 1'b0;
      rd_ff       <= 1'b0;
      rd_d_ff     <= 1'b0;
      wr_ff       <= 1'b0;
      prog_n_ff   <= 1'b1;
      faddr_ff    <= 16'h0000;
      cfg_data_ff <= 16'h0000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        sq_ff[i] <= nxt_sq;
      end
      done_s1_ff  <= cfg_done_in;
      done_s2_ff  <= done_s1_ff;
      rd_ff       <= nxt_rd;
      rd_d_ff     <= rd_ff;
      wr_ff       <= rd_d_ff;
      prog_n_ff   <= nxt_prog_n;
      faddr_ff    <= nxt_faddr;
      cfg_data_ff <= flash_data_in;
    end
  end

  assign cfg_prog_n_out = prog_n_ff;
  assign cfg_wr_out     = wr_ff;
  assign cfg_data_out   = cfg_data_ff;
  assign flash_rd_out   = rd_ff;
  assign flash_addr_out = faddr_ff;

endmodule // cbtmr_top
`default_nettype wire

//--- cbtmr_monitor.sv
// Port-level checker for the configuration bus top
`timescale 1ns/1ns
`default_nettype none
module cbtmr_monitor (
  input wire logic                  core_clk_in,
  input wire logic                  rst_in,
  input wire cbtmr_pkg::cbtmr_txn_t usb_cmd_in,
  input wire logic                  usb_cmd_ready_out,
  input wire logic                  usb_rsp_valid_out,
  input wire cbtmr_pkg::cbtmr_txn_t usb_rsp_out,
  input wire logic                  link_rsp_valid_out,
  input wire logic [15:0]           sensor_clk_en_out,
  input wire logic                  tx_dv_in,
  input wire logic [2:0]            tx_dv_pins_out,
  input wire logic                  i2c_cmd_ready_out,
  input wire logic                  uart_cmd_ready_out,
  input wire logic                  sb_rvalid_out,
  input wire logic                  cfg_prog_n_out,
  input wire logic                  cfg_wr_out,
  input wire logic [15:0]           cfg_data_out,
  input wire logic                  flash_rd_out,
  input wire logic [15:0]           flash_data_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic sb_rdy;
  assign sb_rdy = i2c_cmd_ready_out | uart_cmd_ready_out;
  ////////////////////////////////////////////////////////////
  AST_USB_RSP: assert property (usb_cmd_ready_out |=>
    !usb_cmd_ready_out && usb_rsp_valid_out) else $error("usb rsp late");
  AST_RSP_CAUSE: assert property (usb_rsp_valid_out |->
    $past(usb_cmd_ready_out)) else $error("usb rsp without take");
  AST_ECHO: assert property (usb_rsp_valid_out |->
    usb_rsp_out[30:16] == $past(usb_cmd_in[30:16], 2))
    else $error("usb rsp address mismatch");
  AST_MASK: assert property ($changed(sensor_clk_en_out) |->
    ##[0:1] (usb_rsp_valid_out || link_rsp_valid_out))
    else $error("mask changed without a bus write");
  AST_LINK_PULSE: assert property (link_rsp_valid_out |=>
    !link_rsp_valid_out) else $error("link rsp too long");
  AST_PINS: assert property (!$past(rst_in, 2) |->
    tx_dv_pins_out == {3{$past(tx_dv_in, 2)}}) else $error("dv pins wrong");
  AST_SB_GAP: assert property (sb_rdy |=> !sb_rdy)
    else $error("scrub bus take too soon");
  AST_SB_RD: assert property (sb_rvalid_out |-> sb_rdy)
    else $error("scrub read data without take");
  AST_PROG: assert property ($fell(cfg_prog_n_out) |->
    !cfg_prog_n_out [*8] ##1 !cfg_prog_n_out [*8] ##1 !cfg_prog_n_out [*8]
    ##1 !cfg_prog_n_out ##1 cfg_prog_n_out) else $error("bad prog pulse");
  AST_CFG_WR: assert property (cfg_wr_out |-> $past(flash_rd_out, 2) &&
    cfg_data_out == $past(flash_data_in)) else $error("bad image word");
  COV_USB_WR: cover property (usb_rsp_valid_out && usb_rsp_out.wr);
  COV_LINK: cover property (link_rsp_valid_out);
  COV_SB_RD: cover property (sb_rvalid_out);
  COV_PROG: cover property ($fell(cfg_prog_n_out));
endmodule // cbtmr_monitor
bind cbtmr_top cbtmr_monitor u_cbtmr_monitor (.core_clk_in, .rst_in,
  .usb_cmd_in, .usb_cmd_ready_out, .usb_rsp_valid_out, .usb_rsp_out,
  .link_rsp_valid_out, .sensor_clk_en_out, .tx_dv_in, .tx_dv_pins_out,
  .i2c_cmd_ready_out, .uart_cmd_ready_out, .sb_rvalid_out, .cfg_prog_n_out,
  .cfg_wr_out, .cfg_data_out, .flash_rd_out, .flash_data_in);
`default_nettype wire

//--- cbtmr_partner.sv
// Link sender, flash and programming target seen from the design
`timescale 1ns/1ns
`default_nettype none
module cbtmr_partner #(
  parameter logic [15:0] LAST = 16'h0007
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  sgl_go_in,
  input  wire cbtmr_pkg::cbtmr_txn_t sgl_word_in,
  output logic                       link_dv_out,
  output logic [79:0]                link_frame_out,
  input  wire logic                  flash_rd_in,
  input  wire logic [15:0]           flash_addr_in,
  output logic [15:0]                flash_data_out,
  input  wire logic                  cfg_prog_n_in,
  input  wire logic                  cfg_wr_in,
  output logic                       cfg_done_out
);
  logic [15:0] wr_cnt;
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_dv_out <= 1'b1;
      link_frame_out <= '0;
      flash_data_out <= '0;
      wr_cnt <= '0;
      cfg_done_out <= 1'b0;
    end else begin
      link_dv_out <= !sgl_go_in;
      // Idle frames toggle, repeating the stale word every other cycle; link_dv_out held high keeps it from being taken
      link_frame_out <= sgl_go_in ? {4'h3, 44'h0, sgl_word_in} :
                        ~link_frame_out;
      flash_data_out <= flash_rd_in ? flash_addr_in ^ 16'h5a5a :
                        ~flash_data_out;
      if (!cfg_prog_n_in) begin
        wr_cnt <= '0;
        cfg_done_out <= 1'b0;
      end else if (cfg_wr_in) begin
        wr_cnt <= wr_cnt + 16'h0001;
        cfg_done_out <= cfg_done_out | (wr_cnt == LAST);
      end
    end
  end
endmodule // cbtmr_partner
`default_nettype wire

//--- cbtmr_top_tb_top.sv
// Testbench for the configuration bus, monitor and scrubber
`timescale 1ns/1ns
`default_nettype none
module cbtmr_top_tb_top;
  logic core_clk_in, rst_in, usb_cmd_valid_in, usb_cmd_ready_out;
  logic usb_rsp_valid_out, link_dv_in, link_rsp_valid_out, tx_dv_in;
  logic i2c_cmd_valid_in, i2c_cmd_ready_out, uart_cmd_valid_in, sgl_go;
  logic uart_cmd_ready_out, sb_rvalid_out, cfg_prog_n_out, cfg_wr_out;
  logic cfg_done_in, flash_rd_out;
  cbtmr_pkg::cbtmr_txn_t  usb_cmd_in, usb_rsp_out, link_rsp_out, sgl_word;
  cbtmr_pkg::cbtmr_scmd_t i2c_cmd_in, uart_cmd_in;
  logic [79:0]            link_frame_in;
  logic [15:0]            sensor_clk_en_out, cfg_data_out, flash_addr_out;
  logic [15:0]            flash_data_in;
  logic [7:0]             sb_rdata_out;
  logic [2:0]             tx_dv_pins_out;
  int                     fail_count, checks;
  cbtmr_top #(.IMG_LAST(16'h0007)) u_cbtmr_top (.core_clk_in, .rst_in,
    .usb_cmd_valid_in, .usb_cmd_in, .usb_cmd_ready_out, .usb_rsp_valid_out,
    .usb_rsp_out, .link_dv_in, .link_frame_in, .link_rsp_valid_out,
    .link_rsp_out, .sensor_clk_en_out, .tx_dv_in, .tx_dv_pins_out,
    .i2c_cmd_valid_in, .i2c_cmd_in, .i2c_cmd_ready_out, .uart_cmd_valid_in,
    .uart_cmd_in, .uart_cmd_ready_out, .sb_rvalid_out, .sb_rdata_out,
    .cfg_prog_n_out, .cfg_wr_out, .cfg_data_out, .cfg_done_in,
    .flash_rd_out, .flash_addr_out, .flash_data_in);
  cbtmr_partner #(.LAST(16'h0007)) u_cbtmr_partner (.core_clk_in, .rst_in,
    .sgl_go_in(sgl_go), .sgl_word_in(sgl_word), .link_dv_out(link_dv_in),
    .link_frame_out(link_frame_in), .flash_rd_in(flash_rd_out),
    .flash_addr_in(flash_addr_out), .flash_data_out(flash_data_in),
    .cfg_prog_n_in(cfg_prog_n_out), .cfg_wr_in(cfg_wr_out),
    .cfg_done_out(cfg_done_in));
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic usb(input logic [31:0] c, output logic [31:0] r);
    int n;
    n = 0;
    usb_cmd_in <= c;
    usb_cmd_valid_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (usb_cmd_ready_out !== 1'b1 && n < 40);
    usb_cmd_valid_in <= 1'b0;
    @(posedge core_clk_in);
    chk(usb_rsp_valid_out, 1'b1);
    r = usb_rsp_out;
  endtask
  task automatic link(input logic [31:0] c, output logic [31:0] r);
    int n;
    n = 0;
    sgl_word <= c;
    sgl_go <= 1'b1;
    @(posedge core_clk_in);
    sgl_go <= 1'b0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (link_rsp_valid_out !== 1'b1 && n < 20);
    chk(link_rsp_valid_out, 1'b1);
    r = link_rsp_out;
  endtask
  task automatic sb(input bit u, input logic [15:0] c, output logic [7:0] d);
    int n;
    n = 0;
    if (u) begin
      uart_cmd_in <= c;
      uart_cmd_valid_in <= 1'b1;
    end else begin
      i2c_cmd_in <= c;
      i2c_cmd_valid_in <= 1'b1;
    end
    do begin
      @(posedge core_clk_in);
      n++;
    end while ((u ? uart_cmd_ready_out : i2c_cmd_ready_out) !== 1'b1
               && n < 20);
    d = sb_rdata_out;
    if (u) uart_cmd_valid_in <= 1'b0;
    else i2c_cmd_valid_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    fail_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r, r2;
    logic [7:0]  d;
    int          n;
    {rst_in, usb_cmd_valid_in, tx_dv_in, sgl_go} = 4'h8;
    {i2c_cmd_valid_in, uart_cmd_valid_in, usb_cmd_in, sgl_word} = '0;
    {i2c_cmd_in, uart_cmd_in} = '0;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    chk(sensor_clk_en_out, 16'h0000);
    chk(cfg_prog_n_out, 1'b1);
    repeat (2) @(posedge core_clk_in);
    usb(32'h8115a5c3, r);
    usb(32'h01150000, r);
    chk(r, 32'h0115a5c3);
    // Unmapped module write and unmapped register read
    usb(32'hff151234, r);
    usb(32'h01160000, r);
    chk(r, 32'h01160000);
    chk(sensor_clk_en_out, 16'ha5c3);
    link(32'h81150f0f, r);
    link(32'h01150000, r);
    chk(r, 32'h01150f0f);
    fork
      usb(32'h01150000, r);
      link(32'h81153c3c, r2);
    join
    chk(r, 32'h01150f0f);
    chk(sensor_clk_en_out, 16'h3c3c);
    for (int i = 0; i < 3; i++) begin
      usb({8'h02, i[7:0], 16'h0000}, r);
      chk(r, {8'h02, i[7:0], 16'h0000});
    end
    for (int v = 1; v >= 0; v--) begin
      tx_dv_in <= v[0];
      repeat (3) @(posedge core_clk_in);
      chk(tx_dv_pins_out, {3{v[0]}});
    end
    // Programming run: start over one master, status over the other
    sb(1'b0, 16'h8001, d);
    sb(1'b1, 16'h0100, d);
    chk(d, 8'h02);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(posedge core_clk_in);
        n++;
      end while (cfg_wr_out !== 1'b1 && n < 100);
      chk(cfg_data_out, i[15:0] ^ 16'h5a5a);
    end
    repeat (10) @(posedge core_clk_in);
    sb(1'b0, 16'h0100, d);
    chk(d, 8'h01);
    sb(1'b1, 16'h8003, d);
    repeat (60) @(posedge core_clk_in);
    sb(1'b0, 16'h0100, d);
    chk(d, 8'h10);
    sb(1'b1, 16'h0000, d);
    chk(d, 8'h02);
    sb(1'b0, 16'h8000, d);
    repeat (40) @(posedge core_clk_in);
    sb(1'b1, 16'h0100, d);
    chk(d, 8'h01);
    tally_and_finish();
  end
endmodule // cbtmr_top_tb_top
`default_nettype wire
